// file: rtl/sad_decoder.sv
// board-select address decoder with strap-selected space, width, bank
//
// Contract
// - answer an 8-byte block on an 8-byte boundary, memory or io
// - io compare at 8, 10 or 16 bits, memory at 16, by straps
// - default straps give memory space, 16 bits, base FF08
// - default base answers every address FF08 through FF0F
// - only three window locations live as registers, five inaccessible
// - installed strap wants the line low, removed strap wants it high
// - straps grouped as A10-A15, A8-A9 and A3-A7
// - 8-bit io mode compares only A3 to A7
// - 10-bit io mode compares A3 to A9
// - 10 and 16 bit io place base anywhere in 1024 or 65536
// - io bank ignore selects regardless of the io expansion line
// - memory select optionally qualified by memory expansion line
// - io select optionally qualified by io expansion line
// - memory bank ignore selects in both memory maps
`timescale 1ns/1ps

module sad_decoder
(
    input  wire logic        CLK,                       // 100 MHz clock
    input  wire logic        SYS_RST,                   // sync reset, high
    input  wire logic        CLK_EN,                    // freezes all decode state
    input  wire logic [15:0] BUS_ADDR,                  // bus address pins
    input  wire logic        MEM_REQ_N,                 // memory request
    input  wire logic        IO_REQ_N,                  // io request
    input  wire logic        RD_N,                      // read strobe
    input  wire logic        WR_N,                      // write strobe
    input  wire logic        MEMEX,                     // memory expansion
    input  wire logic        IOEXP,                     // io expansion
    input  wire logic [5:0]  UPPER_ADDRESS_STRAPS,      // A15..A10
    input  wire logic [3:0]  MID_ADDRESS_WIDTH_STRAPS,  // width, A9..A8
    input  wire logic [4:0]  LOW_ADDRESS_STRAPS,        // A7..A3
    input  wire logic        SPACE_TYPE_STRAP,          // 1 memory, 0 io
    input  wire logic [1:0]  MEMORY_BANK_SELECT_STRAP,  // memex mode
    input  wire logic [1:0]  IO_BANK_SELECT_STRAP,      // ioexp mode
    output logic             BOARD_SEL,                 // window hit
    output logic [2:0]       REG_SEL,                   // one-hot live reg
    output logic [2:0]       REG_ADDR,                  // offset in window
    output logic             REG_RD,                    // live reg read
    output logic             REG_WR                     // live reg write
);

    // ========================================================
    // input synchronisers
    // every pin and strap passes two flops; the first stage feeds only
    // the second, so no metastable value reaches the compare logic
    logic [21:0] pin_raw;
    logic [19:0] strap_raw;
    logic [21:0] pin_s1_ff;
    logic [21:0] pin_s2_ff;
    logic [19:0] strap_s1_ff;
    logic [19:0] strap_s2_ff;

    assign pin_raw   = {BUS_ADDR, MEM_REQ_N, IO_REQ_N, RD_N, WR_N,
                        MEMEX, IOEXP};
    assign strap_raw = {UPPER_ADDRESS_STRAPS, MID_ADDRESS_WIDTH_STRAPS,
                        LOW_ADDRESS_STRAPS, SPACE_TYPE_STRAP,
                        MEMORY_BANK_SELECT_STRAP, IO_BANK_SELECT_STRAP};

    // straps reset to the shipped setting so decode is sane at once
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            pin_s1_ff   <= sad_pkg::PIN_IDLE;
            pin_s2_ff   <= sad_pkg::PIN_IDLE;
            strap_s1_ff <= sad_pkg::STRAP_DEF;
            strap_s2_ff <= sad_pkg::STRAP_DEF;
        end
        else if (CLK_EN)
        begin
            pin_s1_ff   <= pin_raw;
            pin_s2_ff   <= pin_s1_ff;
            strap_s1_ff <= strap_raw;
            strap_s2_ff <= strap_s1_ff;
        end
    end

    // ========================================================
    // field split of the synchronised vectors
    logic [15:0] addr;
    logic        mreq_n;
    logic        iorq_n;
    logic        rd_n;
    logic        wr_n;
    logic        memex;
    logic        ioexp;
    logic [5:0]  up_strap;
    logic [1:0]  width_strap;
    logic [1:0]  mid_strap;
    logic [4:0]  low_strap;
    logic        space_strap;
    logic [1:0]  mem_bank;
    logic [1:0]  io_bank;

    assign {addr, mreq_n, iorq_n, rd_n, wr_n, memex, ioexp} = pin_s2_ff;
    assign {up_strap, width_strap, mid_strap, low_strap, space_strap,
            mem_bank, io_bank} = strap_s2_ff;

    // ========================================================
    // per-group address compare; installed strap (1) wants line low
    logic upper_ok;
    logic mid_ok;
    logic low_ok;

    assign upper_ok = (addr[15:10] == ~up_strap);
    assign mid_ok   = (addr[9:8]   == ~mid_strap);
    assign low_ok   = (addr[7:3]   == ~low_strap);

    // width choice; an unused width code falls back to the full compare
    logic io_addr_ok;
    logic mem_addr_ok;

    always_comb
    begin
        unique case (width_strap)
            sad_pkg::WIDTH_8:  io_addr_ok = low_ok;
            sad_pkg::WIDTH_10: io_addr_ok = mid_ok & low_ok;
            sad_pkg::WIDTH_16: io_addr_ok = upper_ok & mid_ok
                                            & low_ok;
            default:           io_addr_ok = upper_ok & mid_ok & low_ok;
        endcase
    end

    // memory space always compares A3 to A15, all three groups
    assign mem_addr_ok = upper_ok & mid_ok & low_ok;

    // ========================================================
    // bank qualification by the expansion lines
    function automatic logic bank_ok(input logic [1:0] mode,
                                     input logic       line);
        logic ok;
        ok = 1'b1;
        unique case (mode)
            sad_pkg::BANK_NORMAL: ok = ~line;
            sad_pkg::BANK_ALT:    ok = line;
            sad_pkg::BANK_IGNORE: ok = 1'b1;
            default:              ok = 1'b1;
        endcase
        return ok;
    endfunction

    logic mem_bank_ok;
    logic io_bank_ok;

    assign mem_bank_ok = bank_ok(mem_bank, memex);
    assign io_bank_ok  = bank_ok(io_bank, ioexp);

    // ========================================================
    // strobe qualification; the space not chosen is never answered
    logic strobe;
    logic mem_hit;
    logic io_hit;
    logic hit;
    logic live;

    assign strobe  = ~rd_n | ~wr_n;
    assign mem_hit = (space_strap == sad_pkg::SPACE_MEM) & ~mreq_n
                     & strobe & mem_addr_ok & mem_bank_ok;
    assign io_hit  = (space_strap == sad_pkg::SPACE_IO) & ~iorq_n
                     & strobe & io_addr_ok & io_bank_ok;
    assign hit     = mem_hit | io_hit;

    // only the first three offsets are live; the rest raise BOARD_SEL alone
    assign live    = (addr[2:0] == sad_pkg::REG_CTRL_OFS)
                   | (addr[2:0] == sad_pkg::REG_DATA_OFS)
                   | (addr[2:0] == sad_pkg::REG_STAT_OFS);

    logic [2:0] nxt_reg_sel;

    assign nxt_reg_sel = {hit & (addr[2:0] == sad_pkg::REG_STAT_OFS),
                          hit & (addr[2:0] == sad_pkg::REG_DATA_OFS),
                          hit & (addr[2:0] == sad_pkg::REG_CTRL_OFS)};

    // ========================================================
    // output registers; a stage of latency traded for clean outputs
    logic       board_sel_ff;
    logic [2:0] reg_sel_ff;
    logic [2:0] reg_addr_ff;
    logic       reg_rd_ff;
    logic       reg_wr_ff;

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            board_sel_ff <= 1'b0;
            reg_sel_ff   <= 3'h0;
            reg_addr_ff  <= 3'h0;
            reg_rd_ff    <= 1'b0;
            reg_wr_ff    <= 1'b0;
        end
        else if (CLK_EN)
        begin
            board_sel_ff <= hit;
            reg_sel_ff   <= nxt_reg_sel;
            reg_addr_ff  <= addr[2:0];
            reg_rd_ff    <= hit & live & ~rd_n;
            reg_wr_ff    <= hit & live & ~wr_n;
        end
    end

    assign BOARD_SEL = board_sel_ff;
    assign REG_SEL   = reg_sel_ff;
    assign REG_ADDR  = reg_addr_ff;
    assign REG_RD    = reg_rd_ff;
    assign REG_WR    = reg_wr_ff;

    // ========================================================
    // checks; outputs trail the pins by three enabled edges
    logic [2:0] ce_hist_ff;

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            ce_hist_ff <= 3'h0;
        else
            ce_hist_ff <= {ce_hist_ff[1:0], CLK_EN};
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_settled;
        ce_hist_ff == 3'h7;
    endsequence

    sequence s_mem_cycle;
        !$past(MEM_REQ_N, 3) && (!$past(RD_N, 3) || !$past(WR_N, 3));
    endsequence

    sequence s_io_cycle;
        !$past(IO_REQ_N, 3) && (!$past(RD_N, 3) || !$past(WR_N, 3));
    endsequence

    chk_default_window: assert property (
        s_settled ##0 s_mem_cycle ##0
        ($past(strap_raw, 3) == sad_pkg::STRAP_DEF &&
         $past(BUS_ADDR[15:3], 3) == sad_pkg::DEFAULT_BASE[15:3])
        |-> BOARD_SEL)
        else $error("default window address not selected");

    chk_default_bounds: assert property (
        s_settled ##0 ($past(strap_raw, 3) == sad_pkg::STRAP_DEF &&
         $past(BUS_ADDR[15:3], 3) != sad_pkg::DEFAULT_BASE[15:3])
        |-> !BOARD_SEL)
        else $error("address outside default window selected");

    chk_strap_polarity: assert property (
        s_settled ##0 BOARD_SEL |->
        $past(BUS_ADDR[7:3], 3) == ~$past(LOW_ADDRESS_STRAPS, 3))
        else $error("low group matched against wrong strap level");

    chk_mem_full16: assert property (
        s_settled ##0 BOARD_SEL && $past(SPACE_TYPE_STRAP, 3) |->
        $past(BUS_ADDR[15:8], 3) ==
        ~{$past(UPPER_ADDRESS_STRAPS, 3),
          $past(MID_ADDRESS_WIDTH_STRAPS[1:0], 3)})
        else $error("memory select without full compare");

    chk_io_8bit: assert property (
        s_settled ##0 s_io_cycle ##0 !$past(SPACE_TYPE_STRAP, 3) &&
        $past(MID_ADDRESS_WIDTH_STRAPS[3:2], 3) == sad_pkg::WIDTH_8 &&
        $past(IO_BANK_SELECT_STRAP, 3) == sad_pkg::BANK_IGNORE &&
        $past(BUS_ADDR[7:3], 3) == ~$past(LOW_ADDRESS_STRAPS, 3)
        |-> BOARD_SEL)
        else $error("8-bit io match not selected");

    chk_io_10bit: assert property (
        s_settled ##0 BOARD_SEL && !$past(SPACE_TYPE_STRAP, 3) &&
        $past(MID_ADDRESS_WIDTH_STRAPS[3:2], 3) == sad_pkg::WIDTH_10 |->
        $past(BUS_ADDR[9:8], 3) == ~$past(MID_ADDRESS_WIDTH_STRAPS[1:0], 3))
        else $error("10-bit io select ignored A9..A8");

    chk_bank_qualify: assert property (
        s_settled ##0 BOARD_SEL && $past(SPACE_TYPE_STRAP, 3) &&
        $past(MEMORY_BANK_SELECT_STRAP, 3) == sad_pkg::BANK_ALT |->
        $past(MEMEX, 3))
        else $error("alternate memory bank selected with memex low");

    chk_io_bank: assert property (
        s_settled ##0 BOARD_SEL && !$past(SPACE_TYPE_STRAP, 3) &&
        $past(IO_BANK_SELECT_STRAP, 3) == sad_pkg::BANK_NORMAL |->
        !$past(IOEXP, 3))
        else $error("normal io bank selected with ioexp high");

    chk_space_only: assert property (
        s_settled ##0 BOARD_SEL |->
        ($past(SPACE_TYPE_STRAP, 3) ? !$past(MEM_REQ_N, 3)
                                    : !$past(IO_REQ_N, 3)))
        else $error("select without request of the chosen space");

    chk_live_regs: assert property (
        (REG_RD || REG_WR || REG_SEL != 3'h0) |->
        BOARD_SEL && $onehot(REG_SEL) && REG_ADDR < 3'h3)
        else $error("register strobe outside the live locations");

    chk_reg_offset: assert property (
        s_settled ##0 BOARD_SEL |-> REG_ADDR == $past(BUS_ADDR[2:0], 3))
        else $error("register offset not taken from low lines");

    chk_freeze_hold: assert property (
        !CLK_EN |=> $stable(BOARD_SEL) && $stable(REG_SEL))
        else $error("outputs changed while clock enable low");

endmodule

// file: rtl/sad_pkg.sv
// constants for the bus board-select address decoder
package sad_pkg;

    // ========================================================
    // address window
    localparam int unsigned ADDR_W      = 16;
    localparam logic [15:0] DEFAULT_BASE = 16'hFF08;
    localparam int unsigned WINDOW_SIZE = 8;   // bytes per board window
    localparam int unsigned LIVE_REGS   = 3;   // live registers in window

    // register offsets inside the window
    localparam logic [2:0] REG_CTRL_OFS = 3'h0;
    localparam logic [2:0] REG_DATA_OFS = 3'h1;
    localparam logic [2:0] REG_STAT_OFS = 3'h2;

    // ========================================================
    // strap encodings (1 = strap installed)
    localparam logic [1:0] WIDTH_16 = 2'h0;   // 16-bit compare
    localparam logic [1:0] WIDTH_10 = 2'h1;   // 10-bit io compare
    localparam logic [1:0] WIDTH_8  = 2'h2;   // 8-bit io compare

    localparam logic [1:0] BANK_IGNORE = 2'h0;  // selected in both maps
    localparam logic [1:0] BANK_NORMAL = 2'h1;  // expansion line low
    localparam logic [1:0] BANK_ALT    = 2'h2;  // expansion line high

    localparam logic SPACE_MEM = 1'h1;
    localparam logic SPACE_IO  = 1'h0;

    // ========================================================
    // strap reset values: memory space, 16 bits, base FF08
    localparam logic [5:0] UPPER_STRAP_DEF = 6'h00;
    localparam logic [3:0] MID_STRAP_DEF   = {WIDTH_16, 2'h0};
    localparam logic [4:0] LOW_STRAP_DEF   = 5'h1E;
    localparam logic [19:0] STRAP_DEF =
        {UPPER_STRAP_DEF, MID_STRAP_DEF, LOW_STRAP_DEF, SPACE_MEM,
         BANK_IGNORE, BANK_IGNORE};

    // bus pins idle: address zero, all strobes released
    localparam logic [21:0] PIN_IDLE = {16'h0000, 6'h3C};

endpackage

// file: sim/sad_bus_master.sv
// bus master model that drives the decoder's address and strobe pins
`timescale 1ns/1ps

module sad_bus_master
(
    input  wire logic   CLK,        // bus clock
    output logic [15:0] BUS_ADDR,   // address lines
    output logic        MEM_REQ_N,  // memory request, low active
    output logic        IO_REQ_N,   // io request, low active
    output logic        RD_N,       // read strobe, low active
    output logic        WR_N,       // write strobe, low active
    output logic        MEMEX,      // memory map select
    output logic        IOEXP       // io map select
);

    // ========================================================
    // idle bus: strobes released, normal maps
    initial
    begin
        BUS_ADDR  = 16'h0000;
        MEM_REQ_N = 1'b1;
        IO_REQ_N  = 1'b1;
        RD_N      = 1'b1;
        WR_N      = 1'b1;
        MEMEX     = 1'b0;
        IOEXP     = 1'b0;
    end

    // ========================================================
    // one request, held until finish is called
    task automatic start(input logic [15:0] addr, input logic mem,
                         input logic rd, input logic mx, input logic ix);
        @(negedge CLK);
        BUS_ADDR  <= addr;
        MEM_REQ_N <= !mem;
        IO_REQ_N  <= mem;
        RD_N      <= !rd;
        WR_N      <= rd;
        MEMEX     <= mx;
        IOEXP     <= ix;
    endtask

    // released address lines do not keep their last value
    task automatic finish();
        @(negedge CLK);
        MEM_REQ_N <= 1'b1;
        IO_REQ_N  <= 1'b1;
        RD_N      <= 1'b1;
        WR_N      <= 1'b1;
        BUS_ADDR  <= ~BUS_ADDR;
    endtask

endmodule

// file: sim/sad_decoder_bench.sv
// self-checking bench for the board-select address decoder
`timescale 1ns/1ps

module sad_decoder_bench;

    typedef struct packed
    {
        logic [19:0] stp;   // upper, mid, low, space, mem bank, io bank
        logic [15:0] addr;  // bus address
        logic [3:0]  cyc;   // memory, read, memex, ioexp
        logic [5:0]  exp;   // select, reg one-hot, read, write
    } sad_row_s;

    logic        clk;
    logic        sys_rst;
    logic        clk_en;
    logic [19:0] straps;
    logic [2:0]  ofs;
    wire  [15:0] bus_addr;
    wire         mem_req_n;
    wire         io_req_n;
    wire         rd_n;
    wire         wr_n;
    wire         memex;
    wire         ioexp;
    logic        board_sel;
    logic [2:0]  reg_sel;
    logic [2:0]  reg_addr;
    logic        reg_rd;
    logic        reg_wr;
    int          fails;
    int          comparisons;

    // ========================================================
    // ordinary cases; strap words follow the package layout
    sad_row_s rows [25] = '{
        '{20'h0_03D0, 16'hFF08, 4'hC, 6'h26},
        '{20'h0_03D0, 16'hFF0A, 4'hA, 6'h31},
        '{20'h0_03D0, 16'hFF0F, 4'hC, 6'h20},
        '{20'h0_03D0, 16'hFF10, 4'hC, 6'h00},
        '{20'h0_03D0, 16'hFF07, 4'hC, 6'h00},
        '{20'h0_03D0, 16'hFF08, 4'h4, 6'h00},
        '{20'hF_EF20, 16'hAB32, 4'h0, 6'h31},
        '{20'hF_EF20, 16'hAB29, 4'h4, 6'h00},
        '{20'hF_EF20, 16'h0032, 4'hC, 6'h00},
        '{20'hF_DB20, 16'hFD31, 4'h4, 6'h2A},
        '{20'hF_DB20, 16'h0231, 4'h4, 6'h00},
        '{20'h9_CB20, 16'h6130, 4'h4, 6'h26},
        '{20'h9_CB20, 16'h6530, 4'h4, 6'h00},
        '{20'h9_CB21, 16'h6130, 4'h5, 6'h00},
        '{20'h9_CB21, 16'h6130, 4'h4, 6'h26},
        '{20'h9_CB22, 16'h6130, 4'h5, 6'h26},
        '{20'h9_CB22, 16'h6130, 4'h4, 6'h00},
        '{20'h9_CB20, 16'h6130, 4'h5, 6'h26},
        '{20'h0_03D4, 16'hFF08, 4'hE, 6'h00},
        '{20'h0_03D8, 16'hFF08, 4'hE, 6'h26},
        '{20'h0_03D8, 16'hFF08, 4'hC, 6'h00},
        '{20'h0_03D4, 16'hFF08, 4'hC, 6'h26},
        // spare width and bank codes act as full compare and ignore
        '{20'h9_FB20, 16'h2130, 4'h4, 6'h00},
        '{20'h9_FB23, 16'h6130, 4'h5, 6'h26},
        '{20'h0_03DC, 16'hFF09, 4'hE, 6'h2A}
    };

    // ========================================================
    // clock, 10 ns period
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    sad_bus_master sad_bus_master_i
    (
        .CLK       (clk),
        .BUS_ADDR  (bus_addr),
        .MEM_REQ_N (mem_req_n),
        .IO_REQ_N  (io_req_n),
        .RD_N      (rd_n),
        .WR_N      (wr_n),
        .MEMEX     (memex),
        .IOEXP     (ioexp)
    );

    sad_decoder sad_decoder_i
    (
        .CLK                      (clk),
        .SYS_RST                  (sys_rst),
        .CLK_EN                   (clk_en),
        .BUS_ADDR                 (bus_addr),
        .MEM_REQ_N                (mem_req_n),
        .IO_REQ_N                 (io_req_n),
        .RD_N                     (rd_n),
        .WR_N                     (wr_n),
        .MEMEX                    (memex),
        .IOEXP                    (ioexp),
        .UPPER_ADDRESS_STRAPS     (straps[19:14]),
        .MID_ADDRESS_WIDTH_STRAPS (straps[13:10]),
        .LOW_ADDRESS_STRAPS       (straps[9:5]),
        .SPACE_TYPE_STRAP         (straps[4]),
        .MEMORY_BANK_SELECT_STRAP (straps[3:2]),
        .IO_BANK_SELECT_STRAP     (straps[1:0]),
        .BOARD_SEL                (board_sel),
        .REG_SEL                  (reg_sel),
        .REG_ADDR                 (reg_addr),
        .REG_RD                   (reg_rd),
        .REG_WR                   (reg_wr)
    );

    // ========================================================
    // compare the select outputs as one word
    task automatic check_out(input logic [5:0] exp, input string what);
        comparisons++;
        if ({board_sel, reg_sel, reg_rd, reg_wr} !== exp)
        begin
            fails++;
            $display("MISMATCH %0t %s got %b want %b", $time, what,
                     {board_sel, reg_sel, reg_rd, reg_wr}, exp);
        end
    endtask

    // straps settle a cycle before the request; 4 edges cover latency 3
    task automatic run_row(input sad_row_s r);
        @(negedge clk);
        straps = r.stp;
        sad_bus_master_i.start(r.addr, r.cyc[3], r.cyc[2], r.cyc[1],
                               r.cyc[0]);
        repeat (4) @(posedge clk);
        @(negedge clk);
        check_out(r.exp, "row");
        sad_bus_master_i.finish();
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // a hang counts as a mismatch and still reaches the verdict
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("MISMATCH %0t run did not finish", $time);
        test_done();
    end

    // ========================================================
    // main sequence
    initial
    begin
        fails = 0;
        comparisons = 0;
        clk_en = 1'b1;
        sys_rst = 1'b1;
        straps = sad_pkg::STRAP_DEF;
        repeat (11) @(posedge clk);
        @(negedge clk);
        check_out(6'h00, "reset");
        @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        $display("test reset done");
        foreach (rows[i]) run_row(rows[i]);
        $display("test table done");
        // back-to-back walk through the whole default window
        @(negedge clk);
        straps = sad_pkg::STRAP_DEF;
        for (int i = 0; i < 11; i++)
        begin
            if (i < 8)
                sad_bus_master_i.start(16'hFF08 + 16'(i), 1'b1, 1'b1,
                                       1'b0, 1'b0);
            else
                @(negedge clk);
            ofs = 3'(i - 3);
            if (i >= 3)
            begin
                check_out({1'b1, (ofs < 3'h3) ? 3'h1 << ofs : 3'h0,
                           ofs < 3'h3, 1'b0}, "walk");
                comparisons++;
                if (reg_addr !== ofs)
                begin
                    fails++;
                    $display("MISMATCH %0t walk offset %0d", $time, ofs);
                end
            end
        end
        sad_bus_master_i.finish();
        $display("test walk done");
        // freeze with clock enable low, then a reset in mid-run
        sad_bus_master_i.start(16'hFF09, 1'b1, 1'b1, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        @(negedge clk);
        check_out(6'h2A, "hit");
        clk_en = 1'b0;
        sad_bus_master_i.finish();
        repeat (6) @(negedge clk);
        check_out(6'h2A, "freeze");
        clk_en = 1'b1;
        repeat (5) @(negedge clk);
        check_out(6'h00, "released");
        sad_bus_master_i.start(16'hFF08, 1'b1, 1'b1, 1'b0, 1'b0);
        repeat (4) @(negedge clk);
        check_out(6'h26, "before reset");
        sys_rst = 1'b1;
        @(negedge clk);
        check_out(6'h00, "mid reset");
        sys_rst = 1'b0;
        sad_bus_master_i.finish();
        // the decoder must answer again once the reset has passed
        sad_bus_master_i.start(16'hFF0A, 1'b1, 1'b0, 1'b0, 1'b0);
        repeat (4) @(negedge clk);
        check_out(6'h31, "after reset");
        sad_bus_master_i.finish();
        $display("test freeze and reset done");
        test_done();
    end

endmodule
